// *** charger_ctrl_pkg.sv ***
package charger_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [7:0] STATUS_OFFSET   = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
    localparam logic [7:0] STRAP_OFFSET    = 8'h10;

    // control register fields
    localparam int CTRL_CHG_DIS_BIT  = 0;
    localparam int CTRL_USB_DIS_BIT  = 1;
    localparam int CTRL_USB_HI_BIT   = 2;
    localparam int CTRL_SLEEP_OFF_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // interrupt event bits
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_TERM_BIT  = 1;
    localparam int IRQ_REG_LOW_BIT = 2;
    localparam int IRQ_PFAIL_BIT = 3;
    localparam int IRQ_SRC_BIT   = 4;
    localparam int IRQ_WIDTH     = 5;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    // usb current limits
    localparam int USB_LIMIT_LOW_MA  = 100;
    localparam int USB_LIMIT_HIGH_MA = 500;

    // usb charge start delay
    localparam int  CLK_MHZ           = 250;
    localparam int  USB_DELAY_US      = 100;
    localparam int  USB_DELAY_CYCLES  = USB_DELAY_US * CLK_MHZ;

    // rail default voltages in millivolts
    localparam logic [11:0] MAIN_DEFAULT_LOW_MV  = 12'h708;
    localparam logic [11:0] MAIN_DEFAULT_HIGH_MV = 12'hCE4;
    localparam logic [11:0] CORE_DEFAULT_LOW_MV  = 12'h514;
    localparam logic [11:0] CORE_DEFAULT_HIGH_MV = 12'h640;

    // serial bus base address with low bit from pin
    localparam logic [6:0] BUS_ADDR_BASE = 7'h48;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SRC_NONE, SRC_AC, SRC_USB} charge_src_t;

endpackage

// *** sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // no reset: the pin levels keep flowing during reset, so straps and
    // levels are already settled at release and no false edge follows it
    always_ff @(posedge aclk) begin
        meta_ff <= d;
        q       <= meta_ff;
    end
endmodule

// *** charger_source_select_ctrl.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1: power fail goes low on battery undervoltage, imminent overtemperature or cover removed.
// R2: alert goes low on charge fault, charge termination or any rail below tolerance.
// R3: main rail default strap selects 1.8 V at 0 and 3.3 V at 1.
// R4: core rail default strap selects 1.3 V at 0 and 1.6 V at 1.
// R5: the address-select pin forms the low bit of the serial bus address.
// R6: a high deep-sleep request lowers or disables the core rail as configured.
// R7: charging starts on its own when ac or usb is above the lockout threshold.
// R8: ac is the preferred source, usb is used only when ac is absent.
// R9: usb charge current is 100 mA after reset and 500 mA once software asks for it.
// R10: software can disable the whole charger or only usb charging.
// R11: usb charging starts only after a delay during which software may disable it.
// R12: ac charging is inhibited while the ac overvoltage comparator is high.
// R13: a low cover input means the battery cover is removed.
// R14: open-drain outputs only pull low and are released otherwise.
module charger_source_select_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ac_undervoltage_lockout_ok,
    input  wire logic        usb_undervoltage_lockout_ok,
    input  wire logic        ac_overvoltage,
    input  wire logic        batt_undervoltage,
    input  wire logic        overtemp_warn,
    input  wire logic        battery_cover_present,
    input  wire logic        charge_fault,
    input  wire logic        charge_done,
    input  wire logic        rail_below_tol,
    input  wire logic        deep_sleep_req,
    input  wire logic        main_rail_default_sel,
    input  wire logic        core_rail_default_sel,
    input  wire logic        bus_addr_low_bit,
    output logic             power_fail_n_o,
    output logic             power_fail_n_oe,
    output logic             alert_n_o,
    output logic             alert_n_oe,
    output logic             irq,
    output logic             charge_en_ac,
    output logic             charge_en_usb,
    output logic             usb_limit_high,
    output logic             core_rail_low,
    output logic             core_rail_off,
    output logic [11:0]      main_rail_default_mv,
    output logic [11:0]      core_rail_default_mv,
    output logic [6:0]       bus_addr
);

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    localparam int NIN = 13;
    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] pin_s;

    assign pin_raw = {ac_undervoltage_lockout_ok, usb_undervoltage_lockout_ok, ac_overvoltage, batt_undervoltage,
                      overtemp_warn, battery_cover_present, charge_fault, charge_done,
                      rail_below_tol, deep_sleep_req, main_rail_default_sel,
                      core_rail_default_sel, bus_addr_low_bit};

    sync2 #(.W(NIN)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pin_raw),
        .q       (pin_s)
    );

    logic ac_ok_s, usb_ok_s, ac_ov_s, batt_uv_s, ot_s, cover_s;
    logic fault_s, done_s, rail_low_s, sleep_s, main_sel_s, core_sel_s, addr_lsb_s;
    assign {ac_ok_s, usb_ok_s, ac_ov_s, batt_uv_s, ot_s, cover_s, fault_s, done_s,
            rail_low_s, sleep_s, main_sel_s, core_sel_s, addr_lsb_s} = pin_s;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus

    localparam int IRQ_W = charger_ctrl_pkg::IRQ_WIDTH;
    logic [3:0]           ctrl_ff;
    logic [IRQ_W-1:0]     irq_stat_ff;
    logic [IRQ_W-1:0]     irq_mask_ff;

    logic        aw_got_ff;
    logic        w_got_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        wr_fire;
    logic [IRQ_W-1:0] w1c;

    assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h0000_0000;
            wstrb_ff      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= charger_ctrl_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff     <= 1'b1;
                awaddr_ff     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff     <= 1'b1;
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_ff)
                    charger_ctrl_pkg::CTRL_OFFSET,
                    charger_ctrl_pkg::IRQ_STAT_OFFSET,
                    charger_ctrl_pkg::IRQ_MASK_OFFSET:
                        s_axi_bresp <= charger_ctrl_pkg::RESP_OKAY;
                    charger_ctrl_pkg::STATUS_OFFSET,
                    charger_ctrl_pkg::STRAP_OFFSET:
                        s_axi_bresp <= charger_ctrl_pkg::RESP_OKAY;
                    default:
                        s_axi_bresp <= charger_ctrl_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    assign w1c = (wr_fire && awaddr_ff == charger_ctrl_pkg::IRQ_STAT_OFFSET && wstrb_ff[0])
                 ? wdata_ff[IRQ_W-1:0] : '0;

    // R9 R10 software controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff     <= charger_ctrl_pkg::CTRL_RESET;
            irq_mask_ff <= charger_ctrl_pkg::IRQ_MASK_RESET;
        end else if (wr_fire && wstrb_ff[0]) begin
            if (awaddr_ff == charger_ctrl_pkg::CTRL_OFFSET)
                ctrl_ff <= wdata_ff[3:0];
            if (awaddr_ff == charger_ctrl_pkg::IRQ_MASK_OFFSET)
                irq_mask_ff <= wdata_ff[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // source selection

    logic        chg_dis, usb_dis;
    logic        ac_usable, usb_present;
    logic [31:0] usb_dly_ff;
    logic        usb_ready_ff;
    logic        pfail;
    charger_ctrl_pkg::charge_src_t src_ff, nxt_src;

    assign chg_dis = ctrl_ff[charger_ctrl_pkg::CTRL_CHG_DIS_BIT];
    assign usb_dis = ctrl_ff[charger_ctrl_pkg::CTRL_USB_DIS_BIT];
    // R12 ac blocked above overvoltage
    assign ac_usable   = ac_ok_s && !ac_ov_s;
    assign usb_present = usb_ok_s;

    // R11 usb start delay, restarts whenever usb drops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_dly_ff   <= 32'h0000_0000;
            usb_ready_ff <= 1'b0;
        end else if (!usb_present) begin
            usb_dly_ff   <= 32'h0000_0000;
            usb_ready_ff <= 1'b0;
        end else if (usb_dly_ff == 32'(charger_ctrl_pkg::USB_DELAY_CYCLES - 1)) begin
            usb_ready_ff <= 1'b1;
        end else begin
            usb_dly_ff <= usb_dly_ff + 32'h0000_0001;
        end
    end

    // R7 R8 autonomous selection, ac first
    always_comb begin
        nxt_src = charger_ctrl_pkg::SRC_NONE;
        if (!chg_dis) begin
            if (ac_usable)
                nxt_src = charger_ctrl_pkg::SRC_AC;
            else if (!ac_ok_s && usb_ready_ff && !usb_dis)
                nxt_src = charger_ctrl_pkg::SRC_USB;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_ff         <= charger_ctrl_pkg::SRC_NONE;
            charge_en_ac   <= 1'b0;
            charge_en_usb  <= 1'b0;
            usb_limit_high <= 1'b0;
        end else begin
            src_ff         <= nxt_src;
            charge_en_ac   <= (nxt_src == charger_ctrl_pkg::SRC_AC);
            charge_en_usb  <= (nxt_src == charger_ctrl_pkg::SRC_USB);
            // R9 usb limit 100/500 mA
            usb_limit_high <= ctrl_ff[charger_ctrl_pkg::CTRL_USB_HI_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status pins, core rail, straps

    // R1 R13 power fail causes, cover low means removed
    assign pfail = batt_uv_s || ot_s || !cover_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_fail_n_o  <= 1'b0;
            power_fail_n_oe <= 1'b0;
            alert_n_o       <= 1'b0;
            alert_n_oe      <= 1'b0;
            core_rail_low   <= 1'b0;
            core_rail_off   <= 1'b0;
        end else begin
            // R14 open drain, only pull low
            power_fail_n_o  <= 1'b0;
            power_fail_n_oe <= pfail;
            // R2 alert on fault, done or rail low
            alert_n_o       <= 1'b0;
            alert_n_oe      <= fault_s || done_s || rail_low_s;
            // R6 deep sleep lowers or disables core
            core_rail_low   <= sleep_s && !ctrl_ff[charger_ctrl_pkg::CTRL_SLEEP_OFF_BIT];
            core_rail_off   <= sleep_s && ctrl_ff[charger_ctrl_pkg::CTRL_SLEEP_OFF_BIT];
        end
    end

    // straps captured once after reset release
    logic strap_done_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_done_ff        <= 1'b0;
            main_rail_default_mv <= charger_ctrl_pkg::MAIN_DEFAULT_LOW_MV;
            core_rail_default_mv <= charger_ctrl_pkg::CORE_DEFAULT_LOW_MV;
            bus_addr             <= charger_ctrl_pkg::BUS_ADDR_BASE;
        end else if (!strap_done_ff) begin
            strap_done_ff        <= 1'b1;
            // R3 main rail default
            main_rail_default_mv <= main_sel_s ? charger_ctrl_pkg::MAIN_DEFAULT_HIGH_MV
                                               : charger_ctrl_pkg::MAIN_DEFAULT_LOW_MV;
            // R4 core rail default
            core_rail_default_mv <= core_sel_s ? charger_ctrl_pkg::CORE_DEFAULT_HIGH_MV
                                               : charger_ctrl_pkg::CORE_DEFAULT_LOW_MV;
            // R5 address low bit from pin
            bus_addr             <= {charger_ctrl_pkg::BUS_ADDR_BASE[6:1], addr_lsb_s};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts

    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] ev_prev_ff;
    assign ev = {src_ff != nxt_src, pfail, rail_low_s, done_s, fault_s};

    // set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_prev_ff  <= '0;
            irq_stat_ff <= '0;
            irq         <= 1'b0;
        end else begin
            ev_prev_ff  <= ev;
            irq_stat_ff <= (irq_stat_ff & ~w1c) | (ev & ~ev_prev_ff);
            irq         <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= charger_ctrl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= charger_ctrl_pkg::RESP_OKAY;
            case (s_axi_araddr)
                charger_ctrl_pkg::CTRL_OFFSET:     s_axi_rdata <= {28'h0, ctrl_ff};
                charger_ctrl_pkg::STATUS_OFFSET:   s_axi_rdata <= {23'h0, sleep_s, usb_ready_ff,
                    ac_ov_s, usb_ok_s, ac_ok_s, pfail, usb_limit_high, charge_en_usb,
                    charge_en_ac};
                charger_ctrl_pkg::IRQ_STAT_OFFSET: s_axi_rdata <= {27'h0, irq_stat_ff};
                charger_ctrl_pkg::IRQ_MASK_OFFSET: s_axi_rdata <= {27'h0, irq_mask_ff};
                charger_ctrl_pkg::STRAP_OFFSET:    s_axi_rdata <= {7'h0, bus_addr,
                    core_rail_default_mv[5:0], main_rail_default_mv};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= charger_ctrl_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// *** charger_ctrl_props.sv ***
`timescale 1ns/1ps
module charger_ctrl_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ac_undervoltage_lockout_ok,
    input wire logic        usb_undervoltage_lockout_ok,
    input wire logic        ac_overvoltage,
    input wire logic        batt_undervoltage,
    input wire logic        overtemp_warn,
    input wire logic        battery_cover_present,
    input wire logic        charge_fault,
    input wire logic        charge_done,
    input wire logic        rail_below_tol,
    input wire logic        deep_sleep_req,
    input wire logic        power_fail_n_o,
    input wire logic        power_fail_n_oe,
    input wire logic        alert_n_o,
    input wire logic        alert_n_oe,
    input wire logic        charge_en_ac,
    input wire logic        charge_en_usb,
    input wire logic        core_rail_low,
    input wire logic        core_rail_off
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0]  up_ff;
    logic [14:0] usb_ff;
    logic        pf_cause;
    logic        al_cause;
    assign pf_cause = batt_undervoltage | overtemp_warn | !battery_cover_present;
    assign al_cause = charge_fault | charge_done | rail_below_tol;
    // settle time after reset, inputs pass a synchroniser first
    always_ff @(posedge aclk) begin
        if (!aresetn) up_ff <= 4'h0;
        else if (up_ff != 4'hF) up_ff <= up_ff + 4'h1;
    end
    // cycles the usb supply has been present
    always_ff @(posedge aclk) begin
        if (!aresetn || !usb_undervoltage_lockout_ok) usb_ff <= 15'h0;
        else if (usb_ff != 15'h7FFF) usb_ff <= usb_ff + 15'h1;
    end
    AST_OD_PULL_ONLY: assert property (!power_fail_n_o && !alert_n_o)
        else $error("open drain data not low");
    AST_PF_SET: assert property ((up_ff > 4'h8 && pf_cause) [*4] |-> power_fail_n_oe)
        else $error("power fail not pulled");
    AST_PF_REL: assert property ((up_ff > 4'h8 && !pf_cause) [*4] |-> !power_fail_n_oe)
        else $error("power fail not released");
    AST_ALERT_SET: assert property ((up_ff > 4'h8 && al_cause) [*4] |-> alert_n_oe)
        else $error("alert not pulled");
    AST_ONE_SRC: assert property (!(charge_en_ac && charge_en_usb))
        else $error("two sources at once");
    AST_AC_WINS: assert property ((up_ff > 4'h8 && ac_undervoltage_lockout_ok) [*5] |-> !charge_en_usb)
        else $error("usb used with ac present");
    AST_OV_INHIBIT: assert property (ac_overvoltage [*5] |-> !charge_en_ac)
        else $error("ac charging in overvoltage");
    AST_USB_DELAY: assert property ($rose(charge_en_usb) |->
        usb_ff >= charger_ctrl_pkg::USB_DELAY_CYCLES)
        else $error("usb charging too early");
    AST_SLEEP: assert property ((up_ff > 4'h8 && deep_sleep_req) [*4] |->
        (core_rail_low || core_rail_off))
        else $error("core rail kept in sleep");
    cover property ($rose(charge_en_usb));
    cover property ($rose(power_fail_n_oe));
    cover property ($rose(core_rail_off));
endmodule
bind charger_source_select_ctrl charger_ctrl_props charger_ctrl_props_inst (.*);

// *** supply_env_model.sv ***
`timescale 1ns/1ps
module supply_env_model (
    input  wire logic [1:0] ac_lvl,
    input  wire logic       usb_lvl,
    output logic            ac_undervoltage_lockout_ok,
    output logic            usb_undervoltage_lockout_ok,
    output logic            ac_overvoltage
);
    // ac level 0 absent, 1 in range, 2 above the overvoltage threshold
    // lockout and overvoltage
    assign ac_undervoltage_lockout_ok     = ac_lvl != 2'h0;
    assign ac_overvoltage = ac_lvl == 2'h2;
    assign usb_undervoltage_lockout_ok    = usb_lvl;
endmodule

// *** charger_source_select_ctrl_tb.sv ***
`timescale 1ns/1ps
module charger_source_select_ctrl_tb;
    logic        aclk, aresetn, usb_lvl, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, ac_lvl, rs, bs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        ac_undervoltage_lockout_ok, usb_undervoltage_lockout_ok, ac_overvoltage, deep_sleep_req;
    logic        batt_undervoltage, overtemp_warn, battery_cover_present;
    logic        charge_fault, charge_done, rail_below_tol;
    logic        main_rail_default_sel, core_rail_default_sel, bus_addr_low_bit;
    logic        power_fail_n_o, power_fail_n_oe, alert_n_o, alert_n_oe;
    logic        charge_en_ac, charge_en_usb, usb_limit_high, core_rail_low, core_rail_off;
    logic [11:0] main_rail_default_mv, core_rail_default_mv;
    logic [6:0]  bus_addr;
    logic [1:0]  ac_t [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic        u_t [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int          miscompares, check_count, ctl_m, n, i, c;
    charger_source_select_ctrl charger_source_select_ctrl_inst (.*);
    supply_env_model supply_env_model_inst (.ac_lvl(ac_lvl), .usb_lvl(usb_lvl),
        .ac_undervoltage_lockout_ok(ac_undervoltage_lockout_ok), .usb_undervoltage_lockout_ok(usb_undervoltage_lockout_ok), .ac_overvoltage(ac_overvoltage));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic timeout();
        miscompares++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // {usb_en, ac_en} expected from supply levels, usb time and control word
    function automatic logic [1:0] src_model(int ac, int usb, int t, int ctl);
        if (ctl[0] || ac == 2) return 2'h0;
        if (ac == 1) return 2'h1;
        if (usb == 1 && !ctl[1] && t >= charger_ctrl_pkg::USB_DELAY_CYCLES) return 2'h2;
        return 2'h0;
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        bs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 100) timeout();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 100) timeout();
    endtask
    task automatic ctl_wr(input int v);
        ctl_m = v;
        axi_wr(8'h00, ctl_m);
    endtask
    task automatic do_reset(input logic m, input logic co, input logic l);
        aresetn <= 1'b0;
        main_rail_default_sel <= m;
        core_rail_default_sel <= co;
        bus_addr_low_bit <= l;
        cyc(5);
        aresetn <= 1'b1;
        ctl_m = 0;
        cyc(4);
        chk(main_rail_default_mv, m ? 12'hCE4 : 12'h708, "main default");
        chk(core_rail_default_mv, co ? 12'h640 : 12'h514, "core default");
        chk(bus_addr, {6'h24, l}, "bus address");
        chk(usb_limit_high, 1'b0, "usb limit reset");
        $display("test reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h18B4B768));
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        s_axi_wstrb <= 4'hF;
        {ac_lvl, usb_lvl, batt_undervoltage, overtemp_warn, deep_sleep_req} <= 6'h00;
        {charge_fault, charge_done, rail_below_tol} <= 3'h0;
        battery_cover_present <= 1'b1;
        do_reset(1'b0, 1'b0, 1'(($urandom)));
        do_reset(1'b1, 1'b1, 1'(($urandom)));
        axi_rd(8'h00);
        chk(rd, 32'h0, "ctrl reset");
        axi_rd(8'h0C);
        chk(rd, 32'h0, "mask reset");
        axi_rd(8'h20);
        chk(rd, 32'h0, "unmapped read data");
        chk(rs, 2'h2, "unmapped read resp");
        axi_wr(8'h20, 32'h0);
        chk(bs, 2'h2, "unmapped write resp");
        ctl_wr(4);
        chk(bs, 2'h0, "write resp");
        cyc(6);
        chk(usb_limit_high, 1'b1, "usb limit high");
        for (c = 0; c < 2; c++) begin
            ctl_wr(c);
            for (i = 0; i < 5; i++) begin
                ac_lvl <= ac_t[i];
                usb_lvl <= u_t[i];
                cyc(6);
                chk({charge_en_usb, charge_en_ac}, src_model(ac_t[i], u_t[i], 0, ctl_m),
                    "source");
            end
        end
        $display("test source table done");
        ctl_wr(0);
        usb_lvl <= 1'b1;
        cyc(charger_ctrl_pkg::USB_DELAY_CYCLES - 10);
        chk(charge_en_usb, 1'b0, "usb early");
        for (n = 0; n < 40 && charge_en_usb !== 1'b1; n++) cyc(1);
        if (n == 40) timeout();
        chk({charge_en_usb, charge_en_ac}, src_model(0, 1, n + 99999, ctl_m), "usb on");
        axi_rd(8'h04);
        chk(rd, 32'hA2, "status word");
        ctl_wr(2);
        ac_lvl <= 2'h1;
        cyc(6);
        chk({charge_en_usb, charge_en_ac}, src_model(1, 1, 99999, ctl_m), "usb off");
        ac_lvl <= 2'h0;
        usb_lvl <= 1'b0;
        ctl_wr(0);
        usb_lvl <= 1'b1;
        cyc(100);
        ctl_wr(2);
        cyc(charger_ctrl_pkg::USB_DELAY_CYCLES + 50);
        chk(charge_en_usb, src_model(0, 1, 99999, ctl_m) >> 1, "usb vetoed");
        usb_lvl <= 1'b0;
        ctl_wr(0);
        $display("test usb delay done");
        axi_wr(8'h08, 32'h1F);
        for (i = 0; i < 6; i++) begin
            {rail_below_tol, charge_done, charge_fault} <= 3'(i >= 3 ? 1 << (i - 3) : 0);
            batt_undervoltage <= (i == 0);
            overtemp_warn <= (i == 1);
            battery_cover_present <= (i != 2);
            cyc(6);
            chk({power_fail_n_oe, alert_n_oe}, {i < 3, i >= 3}, "status pins");
            chk({power_fail_n_o, alert_n_o}, 2'h0, "pull low only");
        end
        {rail_below_tol, batt_undervoltage} <= 2'h0;
        cyc(6);
        chk({power_fail_n_oe, alert_n_oe}, 2'h0, "released");
        $display("test status pins done");
        axi_wr(8'h08, 32'h1F);
        axi_wr(8'h0C, 32'h1);
        charge_fault <= 1'b1;
        cyc(6);
        chk(irq, 1'b1, "irq raised");
        charge_fault <= 1'b0;
        axi_wr(8'h08, 32'h1);
        cyc(3);
        chk(irq, 1'b0, "irq cleared");
        axi_wr(8'h0C, 32'h0);
        charge_done <= 1'b1;
        cyc(6);
        chk(irq, 1'b0, "irq masked");
        axi_rd(8'h08);
        chk(rd, 32'h2, "irq status");
        charge_done <= 1'b0;
        axi_wr(8'h0C, 32'h2);
        cyc(3);
        chk(irq, 1'b1, "irq unmasked");
        $display("test irq done");
        deep_sleep_req <= 1'b1;
        cyc(6);
        chk({core_rail_low, core_rail_off}, 2'h2, "sleep lower");
        ctl_wr(8);
        cyc(6);
        chk(core_rail_off, 1'b1, "sleep off");
        deep_sleep_req <= 1'b0;
        cyc(6);
        chk({core_rail_low, core_rail_off}, 2'h0, "awake");
        $display("test sleep done");
        print_verdict();
    end
endmodule
